// ---- src/rpc_pkg.sv ----
package rpc_pkg;
    localparam int          NCH         = 3;
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 32;
    localparam logic [3:0]  CTRL_OFF    = 4'h0;
    localparam logic [3:0]  LOS_OFF     = 4'h4;
    localparam logic [3:0]  ISTAT_OFF   = 4'h8;
    localparam logic [3:0]  IMASK_OFF   = 4'hc;
    localparam int          CTRL_MUTE   = 0;
    localparam int          CTRL_THR    = 1;
    localparam int          CTRL_MON    = 2;
    localparam int          CTRL_PWR    = 3;
    localparam int          CTRL_W      = 4;
    localparam logic [3:0]  CTRL_RST    = 4'h0;
    localparam logic [2:0]  ISTAT_RST   = 3'h0;
    localparam logic [2:0]  IMASK_RST   = 3'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic {
        RPC_THR_SET_LOW,
        RPC_THR_SET_HIGH
    } rpc_thr_t;
endpackage

// ---- src/rpc_chan_gate.sv ----
`timescale 1ns/100ps
module rpc_chan_gate (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_mute_en,
    input  wire logic i_los,
    input  wire logic i_pos,
    input  wire logic i_neg,
    output logic      o_pos,
    output logic      o_neg
);
    import rpc_pkg::*;

    logic next_pos;
    logic next_neg;
    logic mute;

    always_comb begin
        mute     = i_mute_en & i_los; // RULE12
        next_pos = mute ? 1'b0 : i_pos; // RULE1 RULE2
        next_neg = mute ? 1'b0 : i_neg; // RULE1 RULE2
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pos <= 1'b0;
            o_neg <= 1'b0;
        end else begin
            o_pos <= next_pos;
            o_neg <= next_neg;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_muted_los;
        i_mute_en && i_los;
    endsequence

    property p_mute_low;
        s_muted_los |=> !o_pos && !o_neg;
    endproperty
    a_mute_low: assert property (p_mute_low) // RULE1
        else $error("data not muted during los");

    property p_pass_los;
        (!i_mute_en && i_los) |=>
            (o_pos == $past(i_pos)) && (o_neg == $past(i_neg));
    endproperty
    a_pass_los: assert property (p_pass_los) // RULE2
        else $error("data blocked with muting off");
endmodule

// ---- src/rpc_rx_cfg.sv ----
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
// How it works
// RULE1 - with muting on, a channel in loss of signal drives both data outputs low.
// RULE2 - with muting off, recovered data keeps flowing even during loss of signal.
// RULE3 - in host mode the mute pin becomes the interrupt request output.
// RULE4 - the threshold input picks the high or the low pair of los thresholds.
// RULE5 - the threshold choice counts only while some channel runs ds3 or sts-1.
// RULE6 - a high monitor input puts every receiver in monitor mode, low is normal.
// RULE7 - in host mode the monitor pin becomes the serial data output.
// RULE8 - a low receive-on level powers the whole receive path of every channel off.
// RULE9 - in host mode the receive-on pin becomes the serial data input.
// RULE10 - monitor and receive-on settings go identically to all three channels.
// RULE11 - an undriven receive-on pin reads as low, so receivers stay off.
// RULE12 - each channel mutes from its own los state and the shared mute setting.
module rpc_rx_cfg (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_host_mode,
    input  wire logic                         i_mute_on_los_enable,
    output logic                              o_mute_pin,
    output logic                              o_mute_pin_oe,
    input  wire logic                         i_los_threshold_select,
    input  wire logic                         i_rx_monitor_select,
    output logic                              o_serial_out_pin,
    output logic                              o_serial_out_pin_oe,
    input  wire logic                         i_serial_tx_bit,
    input  wire logic                         i_serial_tx_en,
    input  wire logic                         i_rx_power_on,
    input  wire logic                         i_rx_power_on_driven,
    output logic                              o_serial_in_pin,
    input  wire logic [rpc_pkg::NCH-1:0]      i_chan_ds3_sts1,
    input  wire logic [rpc_pkg::NCH-1:0]      i_los,
    input  wire logic [rpc_pkg::NCH-1:0]      i_recovered_pos_data,
    input  wire logic [rpc_pkg::NCH-1:0]      i_recovered_neg_data,
    output logic      [rpc_pkg::NCH-1:0]      o_recovered_pos_data,
    output logic      [rpc_pkg::NCH-1:0]      o_recovered_neg_data,
    output logic      [rpc_pkg::NCH-1:0]      o_rx_power_enable,
    output logic      [rpc_pkg::NCH-1:0]      o_rx_monitor_mode,
    output rpc_pkg::rpc_thr_t                 o_los_thr_set,
    output logic                              o_irq,
    input  wire logic [rpc_pkg::ADDR_W-1:0]   i_s_axi_awaddr,
    input  wire logic                         i_s_axi_awvalid,
    output logic                              o_s_axi_awready,
    input  wire logic [rpc_pkg::DATA_W-1:0]   i_s_axi_wdata,
    input  wire logic [3:0]                   i_s_axi_wstrb,
    input  wire logic                         i_s_axi_wvalid,
    output logic                              o_s_axi_wready,
    output logic [1:0]                        o_s_axi_bresp,
    output logic                              o_s_axi_bvalid,
    input  wire logic                         i_s_axi_bready,
    input  wire logic [rpc_pkg::ADDR_W-1:0]   i_s_axi_araddr,
    input  wire logic                         i_s_axi_arvalid,
    output logic                              o_s_axi_arready,
    output logic [rpc_pkg::DATA_W-1:0]        o_s_axi_rdata,
    output logic [1:0]                        o_s_axi_rresp,
    output logic                              o_s_axi_rvalid,
    input  wire logic                         i_s_axi_rready
);
    import rpc_pkg::*;

    logic            mute_en;
    logic            next_mute_en;
    rpc_thr_t        next_thr;
    logic [NCH-1:0]  next_mon;
    logic [NCH-1:0]  next_pwr;
    logic            next_mute_pin;
    logic            next_mute_oe;
    logic            next_sout;
    logic            next_sout_oe;
    logic            next_sin;
    logic            next_irq;
    logic            sel_thr;
    logic            sel_mon;
    logic            sel_pwr;
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [NCH-1:0]    istat;
    logic [NCH-1:0]    next_istat;
    logic [NCH-1:0]    imask;
    logic [NCH-1:0]    next_imask;
    logic [NCH-1:0]    los_prev;
    logic [NCH-1:0]    los_rise;
    logic              aw_got;
    logic              next_aw_got;
    logic              w_got;
    logic              next_w_got;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] next_wr_data;
    logic              wr_lane0;
    logic              next_wr_lane0;
    logic              do_wr;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [1:0]        next_rresp;
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        sel_thr = i_host_mode ? ctrl[CTRL_THR] : i_los_threshold_select;
        sel_mon = i_host_mode ? ctrl[CTRL_MON] : i_rx_monitor_select;
        sel_pwr = i_host_mode ? ctrl[CTRL_PWR]
                              : (i_rx_power_on & i_rx_power_on_driven); // RULE11
        next_mute_en = i_host_mode ? ctrl[CTRL_MUTE]
                                   : i_mute_on_los_enable; // RULE3
        next_thr = (|i_chan_ds3_sts1 && sel_thr)
                 ? RPC_THR_SET_HIGH : RPC_THR_SET_LOW; // RULE4 RULE5
        next_mon = {NCH{sel_mon}}; // RULE6 RULE10
        next_pwr = {NCH{sel_pwr}}; // RULE8 RULE10
        next_irq = |(istat & imask);
        next_mute_pin = i_host_mode & next_irq; // RULE3
        next_mute_oe  = i_host_mode; // RULE3
        next_sout     = i_host_mode & i_serial_tx_bit; // RULE7
        next_sout_oe  = i_host_mode & i_serial_tx_en; // RULE7
        next_sin      = i_host_mode & i_rx_power_on; // RULE9
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mute_en             <= 1'b0;
            o_los_thr_set       <= RPC_THR_SET_LOW;
            o_rx_monitor_mode   <= '0;
            o_rx_power_enable   <= '0;
            o_irq               <= 1'b0;
            o_mute_pin          <= 1'b0;
            o_mute_pin_oe       <= 1'b0;
            o_serial_out_pin    <= 1'b0;
            o_serial_out_pin_oe <= 1'b0;
            o_serial_in_pin     <= 1'b0;
        end else begin
            mute_en             <= next_mute_en;
            o_los_thr_set       <= next_thr;
            o_rx_monitor_mode   <= next_mon;
            o_rx_power_enable   <= next_pwr;
            o_irq               <= next_irq;
            o_mute_pin          <= next_mute_pin;
            o_mute_pin_oe       <= next_mute_oe;
            o_serial_out_pin    <= next_sout;
            o_serial_out_pin_oe <= next_sout_oe;
            o_serial_in_pin     <= next_sin;
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_chan
        rpc_chan_gate u_gate (
            .i_ref_clk (i_ref_clk),
            .i_rst     (i_rst),
            .i_mute_en (mute_en),
            .i_los     (i_los[g]),
            .i_pos     (i_recovered_pos_data[g]),
            .i_neg     (i_recovered_neg_data[g]),
            .o_pos     (o_recovered_pos_data[g]),
            .o_neg     (o_recovered_neg_data[g])
        );
    end

    // axi4-lite: address and data may arrive in either order
    always_comb begin
        next_aw_got   = aw_got;
        next_w_got    = w_got;
        next_wr_addr  = wr_addr;
        next_wr_data  = wr_data;
        next_wr_lane0 = wr_lane0;
        next_bvalid   = o_s_axi_bvalid;
        next_bresp    = o_s_axi_bresp;
        if (o_s_axi_awready && i_s_axi_awvalid) begin
            next_aw_got  = 1'b1;
            next_wr_addr = i_s_axi_awaddr;
        end
        if (o_s_axi_wready && i_s_axi_wvalid) begin
            next_w_got    = 1'b1;
            next_wr_data  = i_s_axi_wdata;
            next_wr_lane0 = i_s_axi_wstrb[0];
        end
        do_wr = aw_got && w_got && !o_s_axi_bvalid;
        if (do_wr) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = (wr_addr == CTRL_OFF || wr_addr == LOS_OFF ||
                           wr_addr == ISTAT_OFF || wr_addr == IMASK_OFF)
                        ? RESP_OKAY : RESP_SLVERR;
        end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_rvalid = o_s_axi_rvalid;
        next_rresp  = o_s_axi_rresp;
        next_rdata  = o_s_axi_rdata;
        if (o_s_axi_arready && i_s_axi_arvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = '0;
            if (i_s_axi_araddr == CTRL_OFF) begin
                next_rdata[CTRL_W-1:0] = ctrl;
            end else if (i_s_axi_araddr == LOS_OFF) begin
                next_rdata[NCH-1:0] = i_los;
            end else if (i_s_axi_araddr == ISTAT_OFF) begin
                next_rdata[NCH-1:0] = istat;
            end else if (i_s_axi_araddr == IMASK_OFF) begin
                next_rdata[NCH-1:0] = imask;
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // register updates; a new los event beats a clearing write
    always_comb begin
        los_rise   = i_los & ~los_prev;
        next_ctrl  = ctrl;
        next_imask = imask;
        next_istat = istat;
        if (do_wr && wr_lane0) begin
            if (wr_addr == CTRL_OFF) begin
                next_ctrl = wr_data[CTRL_W-1:0];
            end else if (wr_addr == ISTAT_OFF) begin
                next_istat = istat & ~wr_data[NCH-1:0];
            end else if (wr_addr == IMASK_OFF) begin
                next_imask = wr_data[NCH-1:0];
            end
        end
        next_istat = next_istat | los_rise;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            wr_addr         <= '0;
            wr_data         <= '0;
            wr_lane0        <= 1'b0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready  <= 1'b0;
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_bresp   <= RESP_OKAY;
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rresp   <= RESP_OKAY;
            o_s_axi_rdata   <= '0;
            ctrl            <= CTRL_RST;
            istat           <= ISTAT_RST;
            imask           <= IMASK_RST;
            los_prev        <= '0;
        end else begin
            aw_got          <= next_aw_got;
            w_got           <= next_w_got;
            wr_addr         <= next_wr_addr;
            wr_data         <= next_wr_data;
            wr_lane0        <= next_wr_lane0;
            o_s_axi_awready <= !next_aw_got && !next_bvalid;
            o_s_axi_wready  <= !next_w_got && !next_bvalid;
            o_s_axi_bvalid  <= next_bvalid;
            o_s_axi_bresp   <= next_bresp;
            o_s_axi_arready <= !next_rvalid;
            o_s_axi_rvalid  <= next_rvalid;
            o_s_axi_rresp   <= next_rresp;
            o_s_axi_rdata   <= next_rdata;
            ctrl            <= next_ctrl;
            istat           <= next_istat;
            imask           <= next_imask;
            los_prev        <= i_los;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    property p_irq_pin;
        i_host_mode |=> o_mute_pin_oe && (o_mute_pin == o_irq);
    endproperty
    a_irq_pin: assert property (p_irq_pin) // RULE3
        else $error("mute pin not carrying irq in host mode");

    property p_thr_pick;
        (!i_host_mode && |i_chan_ds3_sts1) |=>
            (o_los_thr_set == RPC_THR_SET_HIGH) ==
            $past(i_los_threshold_select);
    endproperty
    a_thr_pick: assert property (p_thr_pick) // RULE4
        else $error("threshold set does not follow select");

    property p_thr_idle;
        !(|i_chan_ds3_sts1) |=> o_los_thr_set == RPC_THR_SET_LOW;
    endproperty
    a_thr_idle: assert property (p_thr_idle) // RULE5
        else $error("threshold select honoured without ds3 or sts-1");

    property p_mon;
        !i_host_mode |=> o_rx_monitor_mode == {NCH{$past(i_rx_monitor_select)}};
    endproperty
    a_mon: assert property (p_mon) // RULE6
        else $error("monitor mode does not follow input");

    sequence s_host_tx;
        i_host_mode && i_serial_tx_en;
    endsequence
    property p_sout;
        s_host_tx |=> o_serial_out_pin_oe &&
                      o_serial_out_pin == $past(i_serial_tx_bit);
    endproperty
    a_sout: assert property (p_sout) // RULE7
        else $error("serial out pin not driven in host mode");

    property p_pwr_off;
        (!i_host_mode && !i_rx_power_on) |=> o_rx_power_enable == '0;
    endproperty
    a_pwr_off: assert property (p_pwr_off) // RULE8
        else $error("receivers powered with receive-on low");

    property p_sin;
        i_host_mode |=> o_serial_in_pin == $past(i_rx_power_on);
    endproperty
    a_sin: assert property (p_sin) // RULE9
        else $error("serial in pin not sampled in host mode");

    property p_global;
        (&o_rx_power_enable || ~|o_rx_power_enable) &&
        (&o_rx_monitor_mode || ~|o_rx_monitor_mode);
    endproperty
    a_global: assert property (p_global) // RULE10
        else $error("channels got different global settings");

    property p_float;
        (!i_host_mode && !i_rx_power_on_driven) [*2] |=>
            o_rx_power_enable == '0;
    endproperty
    a_float: assert property (p_float) // RULE11
        else $error("undriven receive-on did not read as low");

    property p_indep;
        (mute_en && i_los[0] && !i_los[1]) |=>
            !o_recovered_pos_data[0] &&
            o_recovered_pos_data[1] == $past(i_recovered_pos_data[1]);
    endproperty
    a_indep: assert property (p_indep) // RULE12
        else $error("channel mute not independent");
endmodule

// ---- testbench/rpc_strap_model.sv ----
`timescale 1ns/100ps
// board side of the shared configuration pins: straps plus pin resolution
module rpc_strap_model (
    input  wire logic i_mute_strap,
    input  wire logic i_mon_strap,
    input  wire logic i_pwr_strap,
    input  wire logic i_pwr_drive,
    input  wire logic i_dev_mute_pin,
    input  wire logic i_dev_mute_oe,
    input  wire logic i_dev_sout_pin,
    input  wire logic i_dev_sout_oe,
    output logic      o_mute_wire,
    output logic      o_mon_wire,
    output logic      o_pwr_wire,
    output logic      o_pwr_driven
);
    // straps let go of a pin while the device drives it
    assign o_mute_wire   = i_dev_mute_oe ? i_dev_mute_pin : i_mute_strap;
    assign o_mon_wire    = i_dev_sout_oe ? i_dev_sout_pin : i_mon_strap;
    // undriven receive-on falls to the internal pull-down
    assign o_pwr_wire    = i_pwr_drive ? i_pwr_strap : 1'b0;
    assign o_pwr_driven  = i_pwr_drive;
endmodule

// ---- testbench/receive_section_pin_config_tb_top.sv ----
`timescale 1ns/100ps
module receive_section_pin_config_tb_top;
    import rpc_pkg::*;
    logic              clk = 0, rst = 1, host = 0, thr = 0;
    logic              s_mute = 0, s_mon = 0, s_pwr = 0, s_drv = 0;
    logic              tx_bit = 0, tx_en = 0;
    logic [NCH-1:0]    ds3 = 0, los = 0, pin_p = 0, pin_n = 0;
    logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
    logic [DATA_W-1:0] wdata = 0, rd;
    logic              awvalid = 0, wvalid = 0, bready = 0;
    logic              arvalid = 0, rready = 0;
    logic [1:0]        rsp;
    logic [3:0]        strb = 4'hf;
    logic              mute_w, mon_w, pwr_w, pwr_d;
    wire  logic        mute_o, mute_oe, sout_o, sout_oe, sin_o, irq;
    wire  logic        awready, wready, bvalid, arready, rvalid;
    wire  logic [1:0]  bresp, rresp;
    wire  logic [DATA_W-1:0] rdata;
    wire  logic [NCH-1:0] out_p, out_n, pwr, mon;
    rpc_thr_t          thr_set;
    int                mismatches = 0, checked = 0, cyc = 0;

    always #10 clk = ~clk;

    rpc_strap_model strap_u (.i_mute_strap(s_mute), .i_mon_strap(s_mon),
        .i_pwr_strap(s_pwr), .i_pwr_drive(s_drv),
        .i_dev_mute_pin(mute_o), .i_dev_mute_oe(mute_oe),
        .i_dev_sout_pin(sout_o), .i_dev_sout_oe(sout_oe),
        .o_mute_wire(mute_w), .o_mon_wire(mon_w), .o_pwr_wire(pwr_w),
        .o_pwr_driven(pwr_d));

    rpc_rx_cfg dut_u (.i_ref_clk(clk), .i_rst(rst), .i_host_mode(host),
        .i_mute_on_los_enable(mute_w), .o_mute_pin(mute_o),
        .o_mute_pin_oe(mute_oe), .i_los_threshold_select(thr),
        .i_rx_monitor_select(mon_w), .o_serial_out_pin(sout_o),
        .o_serial_out_pin_oe(sout_oe), .i_serial_tx_bit(tx_bit),
        .i_serial_tx_en(tx_en), .i_rx_power_on(pwr_w),
        .i_rx_power_on_driven(pwr_d), .o_serial_in_pin(sin_o),
        .i_chan_ds3_sts1(ds3), .i_los(los), .i_recovered_pos_data(pin_p),
        .i_recovered_neg_data(pin_n), .o_recovered_pos_data(out_p),
        .o_recovered_neg_data(out_n), .o_rx_power_enable(pwr),
        .o_rx_monitor_mode(mon), .o_los_thr_set(thr_set), .o_irq(irq),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(strb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        s_pwr <= 1'b1;
        repeat (2) @(posedge clk);
        axr(CTRL_OFF);
        chk(rd, 32'(CTRL_RST));
        chk(32'(pwr), 32'h0);
        chk(32'(mute_oe), 32'h0);
        $display("test reset done");
        @(posedge clk);
        pin_p <= 3'h7;
        pin_n <= 3'h7;
        s_mute <= 1'b1;
        los <= 3'h1;
        settle();
        chk(32'(out_p), 32'h6);
        chk(32'(out_n), 32'h6);
        s_mute <= 1'b0;
        settle();
        chk(32'(out_p), 32'h7);
        chk(32'(out_n), 32'h7);
        $display("test muting done");
        thr <= 1'b1;
        ds3 <= 3'h0;
        settle();
        chk(32'(thr_set), 32'(RPC_THR_SET_LOW));
        ds3 <= 3'h4;
        settle();
        chk(32'(thr_set), 32'(RPC_THR_SET_HIGH));
        thr <= 1'b0;
        settle();
        chk(32'(thr_set), 32'(RPC_THR_SET_LOW));
        $display("test threshold done");
        s_mon <= 1'b1;
        s_drv <= 1'b1;
        settle();
        chk(32'(mon), 32'h7);
        chk(32'(pwr), 32'h7);
        s_mon <= 1'b0;
        s_pwr <= 1'b0;
        settle();
        chk(32'(mon), 32'h0);
        chk(32'(pwr), 32'h0);
        $display("test global settings done");
        host <= 1'b1;
        los <= 3'h0;
        s_mute <= 1'b1;
        settle();
        axw(ISTAT_OFF, 32'h7);
        chk(32'(rsp), 32'(RESP_OKAY));
        axw(IMASK_OFF, 32'h1);
        strb <= 4'he;
        axw(IMASK_OFF, 32'h0);
        strb <= 4'hf;
        axr(IMASK_OFF);
        chk(rd, 32'h1);
        axw(4'h2, 32'h7);
        chk(32'(rsp), 32'(RESP_SLVERR));
        axw(CTRL_OFF, 32'hd);
        axr(CTRL_OFF);
        chk(rd, 32'hd);
        chk(32'(mon), 32'h7);
        @(posedge clk);
        los <= 3'h3;
        settle();
        chk(32'(irq), 32'h1);
        chk(32'(mute_w), 32'h1);
        chk(32'(out_p), 32'h4);
        chk(32'(pwr), 32'h7);
        axr(ISTAT_OFF);
        chk(rd, 32'h3);
        axw(ISTAT_OFF, 32'h1);
        settle();
        chk(32'(irq), 32'h0);
        chk(32'(mute_w), 32'h0);
        axr(ISTAT_OFF);
        chk(rd, 32'h2);
        axr(LOS_OFF);
        chk(rd, 32'h3);
        axr(4'h2);
        chk(32'(rsp), 32'(RESP_SLVERR));
        chk(rd, 32'h0);
        $display("test host registers done");
        tx_en <= 1'b1;
        tx_bit <= 1'b1;
        s_pwr <= 1'b1;
        settle();
        chk(32'(sout_oe), 32'h1);
        chk(32'(mon_w), 32'h1);
        chk(32'(sin_o), 32'h1);
        tx_bit <= 1'b0;
        s_pwr <= 1'b0;
        settle();
        chk(32'(mon_w), 32'h0);
        chk(32'(sin_o), 32'h0);
        $display("test serial pins done");
        complete_run();
    end
endmodule
